// ==== core/osrd_consts.vh ====
// Shared constants of the octal serial readout block.
// Included by both design files; holds definitions only.
`ifndef OSRD_CONSTS_VH
`define OSRD_CONSTS_VH

// Result word and channel geometry
`define OSRD_WORD_W        16
`define OSRD_BIT_W         4
`define OSRD_CHANNELS      8
`define OSRD_CH_W          3
`define OSRD_LVDS_OUTS     4
`define OSRD_LAST_BIT      4'hf
`define OSRD_LAST_CH       3'h7

// Two-entry input buffer
`define OSRD_BUF_DEPTH     2
`define OSRD_BUF_CNT_W     2

// Fetch sequence: eight reads plus one cycle of read latency
`define OSRD_FETCH_LAST    4'h8

// Output-standard strap codes: {tied high, floating}
`define OSRD_STD_CMOS      2'h0
`define OSRD_STD_LVDS      2'h2
`define OSRD_STD_LVDS_LP   2'h1

// Reset values
`define OSRD_RST_SYNC      3'h0
`define OSRD_RST_STROBE    3'h7
`define OSRD_RST_OUT       8'h00
`define OSRD_RST_WORD      16'h0000

`endif

// ==== core/osrd_result_mem.v ====
// Small result memory: one write port, one read port with registered data.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "osrd_consts.vh"

module osrd_result_mem #(
  parameter WIDTH  = `OSRD_WORD_W,
  parameter DEPTH  = `OSRD_CHANNELS,
  parameter ADDR_W = `OSRD_CH_W
) (
  input  wire              clk_i,
  input  wire              wr_en_i,
  input  wire [ADDR_W-1:0] wr_addr_i,
  input  wire [WIDTH-1:0]  wr_data_i,
  input  wire [ADDR_W-1:0] rd_addr_i,
  output reg  [WIDTH-1:0]  rd_data_o
);

  reg [WIDTH-1:0] store [0:DEPTH-1];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      store[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= store[rd_addr_i];
  end

endmodule
`default_nettype wire

// ==== core/osrd_readout.v ====
// Conversion control and serial readout of an eight-channel converter.
// Assumes the converter core delivers eight results per conversion start over
// a valid/ready stream, and that strobe, shift clock and straps are pins.
//
// Operation
// - With the rate strap low each serial output moves one bit per shift clock falling edge.
// - With the rate strap high each serial output moves one bit on both shift clock edges.
// - The echo clock is a slightly delayed copy of the shift clock at either rate.
// - Strobe high means acquisition, and the host drives the strobe with a low-jitter pulse.
// - A strobe falling edge starts conversion on all channels and makes results available.
// - Strobe handling does not depend on the output-standard strap.
// - The output-standard strap selects CMOS when low, LVDS when high, low-power LVDS when open.
// - In CMOS mode each of the eight outputs sends its own channel's 16-bit result MSB first.
// - Further shift clocks send the following channels in ascending order with wrap to channel 0.
// - The echo clock disable strap high turns the echo clock off, low keeps it running.
// - Each result is a two's complement word.
// - In LVDS mode each of the four enabled outputs carries two channels back to back, 32 or 16 shift clock periods for both.
// - Outputs release after the strobe rises and drive again after it falls.
`timescale 1ns/1ps
`default_nettype none
`include "osrd_consts.vh"

module osrd_readout #(
  parameter WORD_W   = `OSRD_WORD_W,
  parameter CHANNELS = `OSRD_CHANNELS
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              conversion_strobe_n_i,
  input  wire              shift_clock_i,
  input  wire              rate_select_i,
  input  wire [1:0]        output_standard_i,
  input  wire              echo_clock_disable_i,
  input  wire              sample_valid_i,
  input  wire [WORD_W-1:0] sample_data_i,
  output reg               sample_ready_o,
  output reg               conv_start_o,
  output reg  [CHANNELS-1:0] serial_out_o,
  output reg  [CHANNELS-1:0] serial_out_oe_o,
  output reg               echo_clock_o,
  output reg               lvds_mode_o,
  output reg               low_power_o,
  output reg               data_ready_o
);

  localparam [3:0] ST_ACQ   = 4'h1;
  localparam [3:0] ST_LOAD  = 4'h2;
  localparam [3:0] ST_FETCH = 4'h4;
  localparam [3:0] ST_SHIFT = 4'h8;

  // Bit of channel ch, counted from the MSB, out of the packed result words
  function pick_bit;
    input [CHANNELS*WORD_W-1:0] words;
    input [`OSRD_CH_W-1:0]      ch;
    input [`OSRD_BIT_W-1:0]     pos;
    begin
      pick_bit = words[{ch, `OSRD_LAST_BIT - pos}];
    end
  endfunction

  // Pin synchronisers; stage 1 feeds only stage 2
  reg [2:0] strobe_sync;
  reg [2:0] sck_sync;
  reg [1:0] rate_sync;
  reg [1:0] std_hi_sync;
  reg [1:0] std_fl_sync;
  reg [1:0] echo_dis_sync;

  always @(posedge clk_i) begin
    if (rst_i) begin
      strobe_sync   <= `OSRD_RST_STROBE;
      sck_sync      <= `OSRD_RST_SYNC;
      rate_sync     <= 2'h0;
      std_hi_sync   <= 2'h0;
      std_fl_sync   <= 2'h0;
      echo_dis_sync <= 2'h0;
    end else begin
      strobe_sync   <= {strobe_sync[1:0], conversion_strobe_n_i};
      sck_sync      <= {sck_sync[1:0], shift_clock_i};
      rate_sync     <= {rate_sync[0], rate_select_i};
      std_hi_sync   <= {std_hi_sync[0], output_standard_i[1]};
      std_fl_sync   <= {std_fl_sync[0], output_standard_i[0]};
      echo_dis_sync <= {echo_dis_sync[0], echo_clock_disable_i};
    end
  end

  // Edge detection reads stages 2 and 3 only
  wire strobe_fall = strobe_sync[2] & ~strobe_sync[1];
  wire strobe_rise = ~strobe_sync[2] & strobe_sync[1];
  wire sck_fall    = sck_sync[2] & ~sck_sync[1];
  wire sck_rise    = ~sck_sync[2] & sck_sync[1];
  wire ddr         = rate_sync[1];
  wire shift_edge  = sck_fall | (ddr & sck_rise);
  wire [1:0] std_code = {std_hi_sync[1], std_fl_sync[1]};
  wire lvds        = (std_code != `OSRD_STD_CMOS);

  // Two-entry buffer between the converter core and the result memory.
  // The drain only runs while loading, so results arriving early back up
  // into the core instead of being lost.
  reg [WORD_W-1:0]            buf_head;
  reg [WORD_W-1:0]            buf_tail;
  reg [`OSRD_BUF_CNT_W-1:0]   buf_cnt;
  reg [`OSRD_BUF_CNT_W-1:0]   next_buf_cnt;
  reg [3:0]                   state;
  wire buf_push = sample_valid_i & sample_ready_o;
  wire buf_pop  = (state == ST_LOAD) & (buf_cnt != 2'h0);

  always @* begin
    next_buf_cnt = buf_cnt;
    if (buf_push & ~buf_pop) begin
      next_buf_cnt = buf_cnt + 2'h1;
    end else if (buf_pop & ~buf_push) begin
      next_buf_cnt = buf_cnt - 2'h1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      buf_head       <= `OSRD_RST_WORD;
      buf_tail       <= `OSRD_RST_WORD;
      buf_cnt        <= 2'h0;
      sample_ready_o <= 1'b0;
    end else begin
      buf_cnt        <= next_buf_cnt;
      sample_ready_o <= (next_buf_cnt < `OSRD_BUF_DEPTH);
      if (buf_push & buf_pop) begin
        if (buf_cnt == 2'h1) begin
          buf_head <= sample_data_i;
        end else begin
          buf_head <= buf_tail;
          buf_tail <= sample_data_i;
        end
      end else if (buf_push) begin
        if (buf_cnt == 2'h0) begin
          buf_head <= sample_data_i;
        end else begin
          buf_tail <= sample_data_i;
        end
      end else if (buf_pop) begin
        buf_head <= buf_tail;
      end
    end
  end

  // Result memory: written in channel order, then read back into the shift words
  reg  [`OSRD_CH_W-1:0]       load_cnt;
  reg  [3:0]                  fetch_cnt;
  wire [WORD_W-1:0]           mem_rdata;
  reg  [CHANNELS*WORD_W-1:0]  words;

  osrd_result_mem #(
    .WIDTH  (WORD_W),
    .DEPTH  (CHANNELS),
    .ADDR_W (`OSRD_CH_W)
  ) u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (buf_pop),
    .wr_addr_i (load_cnt),
    .wr_data_i (buf_head),
    .rd_addr_i (fetch_cnt[2:0]),
    .rd_data_o (mem_rdata)
  );

  // Shift position shared by all outputs
  reg [`OSRD_BIT_W-1:0] bit_pos;
  reg [`OSRD_CH_W-1:0]  ch_step;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_ACQ;
      load_cnt     <= 3'h0;
      fetch_cnt    <= 4'h0;
      words        <= {CHANNELS*WORD_W{1'b0}};
      bit_pos      <= 4'h0;
      ch_step      <= 3'h0;
      conv_start_o <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (strobe_rise) begin
        state        <= ST_ACQ;
        data_ready_o <= 1'b0;
      end else if (strobe_fall) begin
        // Same path whatever the output standard
        state        <= ST_LOAD;
        conv_start_o <= 1'b1;
        load_cnt     <= 3'h0;
        bit_pos      <= 4'h0;
        ch_step      <= 3'h0;
        data_ready_o <= 1'b0;
      end else begin
        case (state)
          ST_ACQ: begin
            data_ready_o <= 1'b0;
          end
          ST_LOAD: begin
            if (buf_pop) begin
              load_cnt <= load_cnt + 3'h1;
              if (load_cnt == `OSRD_LAST_CH) begin
                state     <= ST_FETCH;
                fetch_cnt <= 4'h0;
              end
            end
          end
          ST_FETCH: begin
            fetch_cnt <= fetch_cnt + 4'h1;
            if (fetch_cnt != 4'h0) begin
              // Words are kept as delivered, two's complement
              words[{fetch_cnt[2:0] - 3'h1, 4'h0} +: WORD_W] <= mem_rdata;
            end
            if (fetch_cnt == `OSRD_FETCH_LAST) begin
              state        <= ST_SHIFT;
              data_ready_o <= 1'b1;
            end
          end
          ST_SHIFT: begin
            if (shift_edge) begin
              bit_pos <= bit_pos + 4'h1;
              if (bit_pos == `OSRD_LAST_BIT) begin
                ch_step <= ch_step + 3'h1;
              end
            end
          end
          default: begin
            state <= ST_ACQ;
          end
        endcase
      end
    end
  end

  // Serial outputs. A CMOS output k starts at channel k; an LVDS pair k
  // starts at channel 2k and carries two channels back to back.
  integer k;

  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_o    <= `OSRD_RST_OUT;
      serial_out_oe_o <= `OSRD_RST_OUT;
      echo_clock_o    <= 1'b0;
      lvds_mode_o     <= 1'b0;
      low_power_o     <= 1'b0;
    end else begin
      lvds_mode_o  <= lvds;
      low_power_o  <= (std_code == `OSRD_STD_LVDS_LP);
      // Three cycles behind the pin; disabled strap parks it low
      echo_clock_o <= sck_sync[1] & ~echo_dis_sync[1];
      for (k = 0; k < CHANNELS; k = k + 1) begin
        // Driven from the falling strobe, released on the rising one
        serial_out_oe_o[k] <= ~strobe_sync[1] & (~lvds | (k < `OSRD_LVDS_OUTS));
        // Data clears when the strobe releases the pins; outputs 4 to 7, released in LVDS mode, still carry data
        if ((state == ST_SHIFT) & ~strobe_sync[1]) begin
          serial_out_o[k] <= pick_bit(words, (lvds ? {k[1:0], 1'b0} : k[2:0]) + ch_step,
                                      bit_pos);
        end else begin
          serial_out_o[k] <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/osrd_chk.sv ====
// Checker for the octal serial readout: strobe, pin enables, echo clock, straps.
// Sees only the readout's ports and is bound to it below.
`timescale 1ns/1ps
`default_nettype none
module osrd_chk #(
  parameter CHANNELS = 8
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                conversion_strobe_n_i,
  input wire logic                shift_clock_i,
  input wire logic [1:0]          output_standard_i,
  input wire logic                echo_clock_disable_i,
  input wire logic                conv_start_o,
  input wire logic [CHANNELS-1:0] serial_out_o,
  input wire logic [CHANNELS-1:0] serial_out_oe_o,
  input wire logic                echo_clock_o,
  input wire logic                lvds_mode_o,
  input wire logic                low_power_o,
  input wire logic                data_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence sck_quiet;
    $stable(shift_clock_i) [*6];
  endsequence
  sequence strap_held;
    $stable(output_standard_i) [*5];
  endsequence
  a_start_pulse: assert property ($fell(conversion_strobe_n_i) |-> ##[2:4] conv_start_o)
    else $error("no start pulse after strobe fall");
  a_start_once: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  a_drive_on: assert property (conv_start_o |-> serial_out_oe_o[0])
    else $error("pin not driven at conversion start");
  a_drive_off: assert property ($rose(conversion_strobe_n_i)
    |-> ##[2:4] (serial_out_oe_o == '0 && !data_ready_o))
    else $error("pins not released after strobe rise");
  a_idle_quiet: assert property ((serial_out_oe_o == '0) |-> serial_out_o == '0)
    else $error("data on a released pin");
  a_echo_off: assert property (echo_clock_disable_i [*4] |-> !echo_clock_o)
    else $error("echo clock runs while disabled");
  a_echo_copy: assert property (((!echo_clock_disable_i) [*6] and sck_quiet)
    |-> echo_clock_o == shift_clock_i)
    else $error("echo clock differs from shift clock");
  a_lvds_mode: assert property (strap_held |-> lvds_mode_o == |output_standard_i)
    else $error("output standard decode wrong");
  a_low_power: assert property (strap_held |-> low_power_o == (output_standard_i == 2'h1))
    else $error("low power decode wrong");
  a_data_hold: assert property ((data_ready_o && $stable(shift_clock_i)) [*8]
    |-> $stable(serial_out_o))
    else $error("serial data moved without a shift edge");
endmodule
bind osrd_readout osrd_chk #(.CHANNELS(CHANNELS)) u_chk (
  .clk_i, .rst_i, .conversion_strobe_n_i, .shift_clock_i, .output_standard_i,
  .echo_clock_disable_i, .conv_start_o, .serial_out_o, .serial_out_oe_o,
  .echo_clock_o, .lvds_mode_o, .low_power_o, .data_ready_o);
`default_nettype wire

// ==== testbench/osrd_host.sv ====
// Host model: makes the 48 ns shift clock and records the pins after each shifting edge.
// Assumes the bench calls shift only while results are ready.
`timescale 1ns/1ps
`default_nettype none
module osrd_host (
  output logic            shift_clock_o,
  input  wire logic [7:0] serial_out_i
);
  logic [7:0] cap [0:199];
  // Clock stands still between frames
  initial shift_clock_o = 1'b0;
  task shift(input int n, input logic ddr);
    int i;
    cap[0] = serial_out_i;
    for (i = 1; i <= n; i++) begin
      if (!ddr) begin
        shift_clock_o = 1'b1;
        #24;
      end
      shift_clock_o = ddr ? ~shift_clock_o : 1'b0;
      // Sampled late in the half period on the host's own clock, not the echo
      #23 cap[i] = serial_out_i;
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_osrd_readout.sv ====
// Bench for the octal serial readout: feeds results, strobes, checks pins.
// Assumes osrd_host makes the shift clock and records the pins.
`timescale 1ns/1ps
`default_nettype none
module test_osrd_readout;
  logic        clk_i = 0, rst_i = 1, strobe_n = 1, rate = 0, ech_off = 0, valid = 0;
  logic [1:0]  std = 0;
  logic [15:0] data = 0;
  logic [15:0] word [8];
  logic [31:0] lfsr = 32'hcd98d2c5;
  wire         sck, ready, lvds, lp, drdy;
  wire  [7:0]  sout, oe;
  int          n_fail = 0, n_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  osrd_readout DUT (
    .clk_i(clk_i), .rst_i(rst_i), .conversion_strobe_n_i(strobe_n),
    .shift_clock_i(sck), .rate_select_i(rate), .output_standard_i(std),
    .echo_clock_disable_i(ech_off), .sample_valid_i(valid), .sample_data_i(data),
    .sample_ready_o(ready), .conv_start_o(), .serial_out_o(sout),
    .serial_out_oe_o(oe), .echo_clock_o(), .lvds_mode_o(lvds),
    .low_power_o(lp), .data_ready_o(drdy));
  osrd_host host (.shift_clock_o(sck), .serial_out_i(sout));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic exp_bit(input int p, input int i, input logic lv);
    int ch;
    ch = ((lv ? 2 * p : p) + i / 16) % 8;
    return word[ch][15 - i % 16];
  endfunction
  task end_sim;
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task push(input int k);
    int t;
    lfsr = nx(lfsr);
    word[k] = lfsr[15:0];
    repeat (lfsr[17:16] + 1) @(posedge clk_i);
    valid <= 1'b1;
    data <= word[k];
    for (t = 0; t < 60; t++) begin
      @(posedge clk_i);
      if (ready === 1'b1) break;
    end
    valid <= 1'b0;
    if (t == 60) begin
      n_fail++;
      end_sim;
    end
  endtask
  task conv(input logic r, input logic [1:0] s, input logic e, input int nb);
    int i, p;
    @(posedge clk_i);
    rate <= r;
    std <= s;
    ech_off <= e;
    push(0);
    push(1);
    repeat (2) @(posedge clk_i);
    #1 chk(ready, 0);
    @(posedge clk_i);
    strobe_n <= 1'b0;
    for (i = 2; i < 8; i++) push(i);
    for (i = 0; i < 200 && drdy !== 1'b1; i++) @(posedge clk_i);
    if (drdy !== 1'b1) begin
      n_fail++;
      end_sim;
    end
    // First data bit is launched by the edge after the one that raised the ready flag
    @(posedge clk_i);
    host.shift(nb, r);
    for (i = 0; i <= nb; i++)
      for (p = 0; p < 8; p++)
        if (s == 2'h0 || p < 4)
          chk(host.cap[i][p], exp_bit(p, i, |s));
    chk(lvds, |s);
    chk(lp, s == 2'h1);
    @(posedge clk_i);
    strobe_n <= 1'b1;
    for (i = 0; i < 20 && oe !== 8'h00; i++) @(posedge clk_i);
    chk(oe, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    conv(1'b0, 2'h0, 1'b0, 136);
    conv(1'b1, 2'h2, 1'b0, 40);
    conv(1'b1, 2'h1, 1'b1, 20);
    conv(1'b0, 2'h2, 1'b0, 34);
    end_sim;
  end
endmodule
`default_nettype wire
